//--- verilog/psf_defs.svh
`ifndef PSF_DEFS_SVH
`define PSF_DEFS_SVH

// Device register addresses
`define PSF_ADDR_CFG      8'h37
`define PSF_ADDR_WR_IDX   8'h38
`define PSF_ADDR_RD_IDX   8'h39
`define PSF_ADDR_LOST     8'h3a
`define PSF_ADDR_DATA     8'h3b
`define PSF_ADDR_PART     8'h3d

// Configuration fields, reset values, loss limit and part identifier
`define PSF_CFG_ROLL_BIT  4
`define PSF_CFG_THR_MSB   3
`define PSF_CFG_THR_LSB   0
`define PSF_CFG_RESET     8'h00
`define PSF_IDX_RESET     5'h00
`define PSF_LOST_RESET    4'h0
`define PSF_LOST_MAX      4'hf
`define PSF_PART_IDENTIFIER       8'h5a

// Host APB register offsets
`define PSF_APB_CMD       12'h000
`define PSF_APB_WDATA     12'h004
`define PSF_APB_STATUS    12'h008
`define PSF_APB_RDATA     12'h00c
`define PSF_APB_IRQ_STAT  12'h010
`define PSF_APB_IRQ_MASK  12'h014

// Command word fields
`define PSF_CMD_WRITE_BIT 8
`define PSF_CMD_ADDR_MSB  7

// Interrupt status bits
`define PSF_IRQ_DONE      0
`define PSF_IRQ_AFULL     1
`define PSF_IRQ_ERR       2

`endif

//--- verilog/psf_pkg.sv
`default_nettype none
package psf_pkg;
  typedef logic [17:0] psf_sample_t;
  typedef logic [7:0]  psf_byte_t;
  typedef logic [7:0]  psf_addr_t;
  typedef enum logic [1:0] {PSF_BYTE_LOW, PSF_BYTE_MID, PSF_BYTE_TOP} psf_byte_pos_t;
endpackage
`default_nettype wire

//--- verilog/psf_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psf_link_if;
  import psf_pkg::*;
  logic      req;
  logic      write;
  psf_addr_t addr;
  psf_byte_t wdata;
  logic      ack;
  psf_byte_t rdata;
  logic      irq;

  modport dev (
    input  req,
    input  write,
    input  addr,
    input  wdata,
    output ack,
    output rdata,
    output irq
  );
  modport host (
    output req,
    output write,
    output addr,
    output wdata,
    input  ack,
    input  rdata,
    input  irq
  );
endinterface
`default_nettype wire

//--- verilog/psf_fifo_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "psf_defs.svh"

// Overview of operation
// (R1) Rollover on: always store, bump write index
// (R2) Full rollover: overwrite oldest, read index kept
// (R3) Rollover off and full: drop sample
// (R4) 4-bit threshold counts empty words; 0=full
// (R5) Interrupt at 32-N unread samples
// (R6) Host uses even threshold in paired mode
// (R7) 5-bit write index, auto increment
// (R8) Host clears indices before measurement start
// (R9) Uncleared write index used as is
// (R10) Read index bumps after third byte
// (R11) Host may rewrite read index
// (R12) Rollover losses counted, saturating at 15
// (R13) Data port shows sample at read index
// (R14) Data port address never advances
// (R15) Samples held as 18-bit values
// (R16) Byte order low, middle, top two bits
// (R17) Indices wrap; almost-full at or below threshold
// (R18) Read index write restarts byte position
module psf_fifo_dev #(
  parameter int DEPTH = 32
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic            ce,
  input  wire logic            sample_valid,
  input  wire psf_pkg::psf_sample_t sample_data,
  psf_link_if.dev              link
);
  import psf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0]    cfg;
  logic [4:0]    wr_idx;
  logic [4:0]    rd_idx;
  logic [3:0]    lost;
  logic [5:0]    count;
  psf_byte_pos_t pos;
  psf_sample_t   mem [DEPTH];
  psf_byte_t     rdata_q;
  logic          ack_q;
  logic          irq_q;

  function automatic logic [4:0] inc5(input logic [4:0] v);
    return 5'(v + 5'h01);
  endfunction

  wire        roll     = cfg[`PSF_CFG_ROLL_BIT];
  wire [3:0]  thr      = cfg[`PSF_CFG_THR_MSB:`PSF_CFG_THR_LSB];
  wire        full     = (count == 6'(DEPTH));
  wire [5:0]  empty    = 6'(6'(DEPTH) - count);
  wire        acc      = ce && link.req && !ack_q;
  wire        wr_acc   = acc && link.write;
  wire        rd_acc   = acc && !link.write;
  wire        hit_wr   = wr_acc && link.addr == `PSF_ADDR_WR_IDX;
  wire        hit_rd   = wr_acc && link.addr == `PSF_ADDR_RD_IDX;
  wire        hit_lost = wr_acc && link.addr == `PSF_ADDR_LOST;
  wire        hit_cfg  = wr_acc && link.addr == `PSF_ADDR_CFG;
  wire        pop_data = rd_acc && link.addr == `PSF_ADDR_DATA;
  // (R1) (R3) Store gating; full without rollover drops
  wire        store    = sample_valid && (roll || !full);
  // (R10) Pop after third byte
  wire        pop      = pop_data && pos == PSF_BYTE_TOP && count != 6'h00;
  wire        overwrite = store && full;
  wire        grow      = store && !full;
  // (R2) Overwrite keeps the read index; a coinciding pop is dropped
  wire        shrink    = pop && !overwrite;

  // Fill level follows the pointers; a pointer write resyncs it
  wire [4:0]  new_wr    = hit_wr ? link.wdata[4:0] : wr_idx;
  wire [4:0]  new_rd    = hit_rd ? link.wdata[4:0] : rd_idx;
  wire [5:0]  resync    = {1'b0, 5'(new_wr - new_rd)};
  wire [5:0]  next_count =
    (hit_wr || hit_rd) ? resync :
    (grow && !shrink)  ? 6'(count + 6'h01) :
    (shrink && !grow)  ? 6'(count - 6'h01) : count;
  // (R4) (R5) (R17) Almost-full on empty words
  wire        afull_now = (empty <= {2'b00, thr});
  psf_sample_t cur;
  // (R13) Sample at read index
  assign cur = mem[rd_idx];
  // (R16) Byte selection
  wire [7:0]  data_byte = (pos == PSF_BYTE_LOW) ? cur[7:0] :
                          (pos == PSF_BYTE_MID) ? cur[15:8] : {6'h00, cur[17:16]};
  wire [7:0]  next_rdata =
    (link.addr == `PSF_ADDR_CFG)    ? cfg :
    (link.addr == `PSF_ADDR_WR_IDX) ? {3'h0, wr_idx} :
    (link.addr == `PSF_ADDR_RD_IDX) ? {3'h0, rd_idx} :
    (link.addr == `PSF_ADDR_LOST)   ? {4'h0, lost} :
    (link.addr == `PSF_ADDR_DATA)   ? data_byte :
    (link.addr == `PSF_ADDR_PART)   ? `PSF_PART_IDENTIFIER : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // (R9) (R15) Full 18-bit word at the current write index
  always_ff @(posedge clk) begin
    if (ce && store) begin
      mem[wr_idx] <= sample_data;
    end
  end

  // One ack per accepted request; read data stands until the next read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_q   <= 1'b0;
      rdata_q <= 8'h00;
    end else if (ce) begin
      ack_q <= acc;
      if (rd_acc) begin
        rdata_q <= next_rdata;
      end
    end
  end

  // Unused upper bits read back as zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg <= `PSF_CFG_RESET;
    end else if (ce && hit_cfg) begin
      cfg <= {3'h0, link.wdata[4:0]};
    end
  end

  // (R7) Write index bump, (R17) wraps
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_idx <= `PSF_IDX_RESET;
    end else if (ce) begin
      if (hit_wr) begin
        wr_idx <= link.wdata[4:0];
      end else if (store) begin
        wr_idx <= inc5(wr_idx);
      end
    end
  end

  // (R11) Host reload of read index
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_idx <= `PSF_IDX_RESET;
    end else if (ce) begin
      if (hit_rd) begin
        rd_idx <= link.wdata[4:0];
      end else if (shrink) begin
        rd_idx <= inc5(rd_idx);
      end
    end
  end

  // Advances on every data-port read, even when empty
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pos <= PSF_BYTE_LOW;
    end else if (ce) begin
      // (R18) Byte position restart
      if (hit_rd) begin
        pos <= PSF_BYTE_LOW;
      end else if (pop_data) begin
        // (R14) Same address, next byte
        unique case (pos)
          PSF_BYTE_LOW: pos <= PSF_BYTE_MID;
          PSF_BYTE_MID: pos <= PSF_BYTE_TOP;
          PSF_BYTE_TOP: pos <= PSF_BYTE_LOW;
          default:      pos <= PSF_BYTE_LOW;
        endcase
      end
    end
  end

  // (R12) Saturating loss count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      lost <= `PSF_LOST_RESET;
    end else if (ce) begin
      if (hit_lost) begin
        lost <= link.wdata[3:0];
      end else if (overwrite && lost != `PSF_LOST_MAX) begin
        lost <= 4'(lost + 4'h1);
      end
    end
  end

  // Kept apart from the indices: equal indices are empty or full
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count <= 6'h00;
    end else if (ce) begin
      count <= next_count;
    end
  end

  // Registered so the pin comes straight from a flop
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      irq_q <= afull_now;
    end
  end

  assign link.ack   = ack_q;
  assign link.rdata = rdata_q;
  assign link.irq   = irq_q;
endmodule
`default_nettype wire

//--- verilog/psf_fifo_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "psf_defs.svh"

module psf_fifo_host (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  psf_link_if.host         link
);
  import psf_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [8:0]  cmd;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        busy;
  logic [2:0]  istat;
  logic [2:0]  imask;
  logic        req_q;
  logic        irq_s1;
  logic        irq_s2;
  logic        irq_prev;

  wire access  = ce && psel && penable && !pready;
  wire wr      = access && pwrite;
  wire rd      = access && !pwrite;
  wire hit_cmd = paddr == `PSF_APB_CMD;
  wire mapped  = hit_cmd || paddr == `PSF_APB_WDATA || paddr == `PSF_APB_STATUS ||
                 paddr == `PSF_APB_RDATA || paddr == `PSF_APB_IRQ_STAT || paddr == `PSF_APB_IRQ_MASK;
  // Command while busy is refused rather than queued
  wire err     = !mapped || (wr && hit_cmd && busy);
  wire start   = wr && hit_cmd && !busy;
  wire done    = req_q && link.ack;
  wire afull_r = irq_s2 && !irq_prev;
  wire clr     = rd && paddr == `PSF_APB_IRQ_STAT;
  wire [2:0] ev = {access && err, afull_r, done};
  wire [31:0] rmux =
    (paddr == `PSF_APB_CMD)      ? {23'h0, cmd} :
    (paddr == `PSF_APB_WDATA)    ? {24'h0, wbyte} :
    (paddr == `PSF_APB_STATUS)   ? {30'h0, irq_s2, busy} :
    (paddr == `PSF_APB_RDATA)    ? {24'h0, rbyte} :
    (paddr == `PSF_APB_IRQ_STAT) ? {29'h0, istat} :
    (paddr == `PSF_APB_IRQ_MASK) ? {29'h0, imask} : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd      <= 9'h000;
      wbyte    <= 8'h00;
      rbyte    <= 8'h00;
      busy     <= 1'b0;
      istat    <= 3'h0;
      imask    <= 3'h0;
      req_q    <= 1'b0;
      irq_s1   <= 1'b0;
      irq_s2   <= 1'b0;
      irq_prev <= 1'b0;
      prdata   <= 32'h0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      irq      <= 1'b0;
    end else if (ce) begin
      irq_s1   <= link.irq;
      irq_s2   <= irq_s1;
      irq_prev <= irq_s2;
      pready   <= access;
      pslverr  <= access && err;
      if (rd) begin
        prdata <= rmux;
      end
      if (wr && paddr == `PSF_APB_WDATA) begin
        wbyte <= pwdata[7:0];
      end
      if (wr && paddr == `PSF_APB_IRQ_MASK) begin
        imask <= pwdata[2:0];
      end
      // (R8) (R11) Software issues pointer writes as commands
      if (start) begin
        cmd   <= pwdata[8:0];
        busy  <= 1'b1;
        req_q <= 1'b1;
      end else if (done) begin
        busy  <= 1'b0;
        req_q <= 1'b0;
        // (R15) (R16) Bytes passed as read; software assembles 18 bits
        if (!cmd[`PSF_CMD_WRITE_BIT]) begin
          rbyte <= link.rdata;
        end
      end
      // Set wins over read-clear
      istat <= (clr ? 3'h0 : istat) | ev;
      irq   <= |(((clr ? 3'h0 : istat) | ev) & imask);
    end
  end

  assign link.req   = req_q;
  assign link.write = cmd[`PSF_CMD_WRITE_BIT];
  assign link.addr  = cmd[`PSF_CMD_ADDR_MSB:0];
  assign link.wdata = wbyte;
endmodule
`default_nettype wire

//--- dv/psf_link_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "psf_defs.svh"
module psf_link_sva (
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               req,
  input wire logic               write,
  input wire psf_pkg::psf_addr_t addr,
  input wire psf_pkg::psf_byte_t wdata,
  input wire logic               ack,
  input wire psf_pkg::psf_byte_t rdata,
  input wire logic               irq
);
  import psf_pkg::*;
  logic [1:0] pos;
  wire        dp_rd = ack && !write && addr == `PSF_ADDR_DATA;
  // Mirror of byte slot, so the top byte can be judged on its own
  always_ff @(posedge clk) begin
    if (!nrst)
      pos <= 2'h0;
    else if (ack && write && addr == `PSF_ADDR_RD_IDX)
      pos <= 2'h0;
    else if (dp_rd)
      pos <= (pos == 2'h2) ? 2'h0 : pos + 2'h1;
  end
  ////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held too long");
  a_ack_latency: assert property (req && !ack |=> ack)
    else $error("ack late");
  a_ack_cause: assert property (ack |-> req && $past(req))
    else $error("ack without request");
  a_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(write) && $stable(wdata))
    else $error("request changed before ack");
  a_rdata_hold: assert property ($changed(rdata) |-> ack && !write)
    else $error("read data moved without read");
  a_index_width: assert property (ack && !write && (addr == `PSF_ADDR_WR_IDX || addr == `PSF_ADDR_RD_IDX) |-> rdata[7:5] == 3'h0)
    else $error("index upper bits set");
  a_lost_width: assert property (ack && !write && addr == `PSF_ADDR_LOST |-> rdata[7:4] == 4'h0)
    else $error("lost counter upper bits set");
  a_top_byte: assert property (dp_rd && pos == 2'h2 |-> rdata[7:2] == 6'h00)
    else $error("third byte above bit 1");
  a_irq_release: assert property ($rose(nrst) |-> !irq)
    else $error("almost full at reset release");
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psf_defs.svh"
module tb;
  import psf_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        ce = 1'b1;
  logic        sample_valid = 1'b0;
  psf_sample_t sample_data = 18'h0;
  logic [31:0] rd_val;
  logic        err_val;
  int          error_cnt = 0;
  int          cmp_count = 0;
  psf_link_if link ();
  psf_fifo_dev psf_fifo_dev_inst (.clk(clk), .nrst(nrst), .ce(ce), .sample_valid(sample_valid),
    .sample_data(sample_data), .link(link));
  psf_fifo_host psf_fifo_host_inst (.clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .link(link));
  psf_link_sva psf_link_sva_inst (.clk(clk), .nrst(nrst), .req(link.req), .write(link.write), .addr(link.addr),
    .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata), .irq(link.irq));
  always #2.5 clk = ~clk;
  ////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Idle edge first, so back to back calls never drive twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_val = prdata;
    err_val = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) error_cnt++;
  endtask
  task automatic dev(input logic w, input psf_addr_t a, input psf_byte_t d);
    int n;
    n = 0;
    apb(1'b1, `PSF_APB_WDATA, {24'h0, d});
    apb(1'b1, `PSF_APB_CMD, {23'h0, w, a});
    do begin
      apb(1'b0, `PSF_APB_IRQ_STAT, 32'h0);
      n++;
    end while (rd_val[`PSF_IRQ_DONE] !== 1'b1 && n < 40);
    if (rd_val[`PSF_IRQ_DONE] !== 1'b1) error_cnt++;
    apb(1'b0, `PSF_APB_RDATA, 32'h0);
  endtask
  task automatic rchk(input psf_addr_t a, input psf_byte_t e);
    dev(1'b0, a, 8'h00);
    chk($sformatf("dev reg %h", a), {24'h0, rd_val[7:0]}, {24'h0, e});
  endtask
  task automatic push(input psf_sample_t d);
    @(posedge clk);
    sample_valid <= 1'b1;
    sample_data <= d;
    @(posedge clk);
    sample_valid <= 1'b0;
  endtask
  task automatic setup(input psf_byte_t cfg);
    dev(1'b1, `PSF_ADDR_CFG, cfg);
    dev(1'b1, `PSF_ADDR_WR_IDX, 8'h00);
    dev(1'b1, `PSF_ADDR_RD_IDX, 8'h00);
    dev(1'b1, `PSF_ADDR_LOST, 8'h00);
  endtask
  ////////////////////////////////
  task automatic t_reset;
    rchk(`PSF_ADDR_WR_IDX, 8'h00);
    rchk(`PSF_ADDR_RD_IDX, 8'h00);
    rchk(`PSF_ADDR_LOST, 8'h00);
    rchk(`PSF_ADDR_PART, `PSF_PART_IDENTIFIER);
    rchk(8'h3c, 8'h00);
    apb(1'b0, 12'h020, 32'h0);
    chk("apb refusal", {31'h0, err_val}, 32'h1);
    apb(1'b0, `PSF_APB_IRQ_STAT, 32'h0);
    chk("apb error status", {31'h0, rd_val[`PSF_IRQ_ERR]}, 32'h1);
  endtask
  task automatic t_order;
    push(18'h2a5c3);
    push(18'h13c7e);
    rchk(`PSF_ADDR_WR_IDX, 8'h02);
    rchk(`PSF_ADDR_DATA, 8'hc3);
    rchk(`PSF_ADDR_DATA, 8'ha5);
    rchk(`PSF_ADDR_RD_IDX, 8'h00);
    rchk(`PSF_ADDR_DATA, 8'h02);
    rchk(`PSF_ADDR_RD_IDX, 8'h01);
    dev(1'b1, `PSF_ADDR_RD_IDX, 8'h00);
    rchk(`PSF_ADDR_DATA, 8'hc3);
    // Start at a loaded index, then wrap
    dev(1'b1, `PSF_ADDR_WR_IDX, 8'h1e);
    push(18'h0003c);
    push(18'h00011);
    rchk(`PSF_ADDR_WR_IDX, 8'h00);
    dev(1'b1, `PSF_ADDR_RD_IDX, 8'h1e);
    rchk(`PSF_ADDR_DATA, 8'h3c);
    // Low clock enable freezes the store
    @(posedge clk);
    ce <= 1'b0;
    push(18'h3ffff);
    @(posedge clk);
    ce <= 1'b1;
    rchk(`PSF_ADDR_WR_IDX, 8'h00);
  endtask
  task automatic t_fill(input psf_byte_t cfg, input int cnt, input psf_byte_t wr, input psf_byte_t lost,
    input psf_byte_t first);
    setup(cfg);
    for (int i = 0; i < cnt; i++)
      push({10'h0, 8'(i)});
    rchk(`PSF_ADDR_WR_IDX, wr);
    rchk(`PSF_ADDR_RD_IDX, 8'h00);
    rchk(`PSF_ADDR_LOST, lost);
    rchk(`PSF_ADDR_DATA, first);
  endtask
  task automatic t_irq;
    // Even threshold, safe for paired mode
    setup(8'h02);
    apb(1'b1, `PSF_APB_IRQ_MASK, 32'h0);
    apb(1'b0, `PSF_APB_IRQ_STAT, 32'h0);
    repeat (29) push(18'h00055);
    repeat (8) @(posedge clk);
    chk("dev irq early", {31'h0, link.irq}, 32'h0);
    push(18'h00055);
    repeat (8) @(posedge clk);
    chk("dev irq", {31'h0, link.irq}, 32'h1);
    apb(1'b0, `PSF_APB_STATUS, 32'h0);
    chk("host status", rd_val, 32'h2);
    chk("host irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, `PSF_APB_IRQ_MASK, 32'h2);
    repeat (4) @(posedge clk);
    chk("host irq", {31'h0, irq}, 32'h1);
    apb(1'b0, `PSF_APB_IRQ_STAT, 32'h0);
    chk("afull status", {31'h0, rd_val[`PSF_IRQ_AFULL]}, 32'h1);
    repeat (4) @(posedge clk);
    chk("host irq cleared", {31'h0, irq}, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_order;
    // Rollover off: 33rd sample dropped, slot 0 keeps sample 0
    t_fill(8'h00, 33, 8'h00, 8'h00, 8'h00);
    // Rollover on: 17 overwrites, counter saturates
    t_fill(8'h10, 49, 8'h11, 8'h0f, 8'h20);
    t_irq;
    report_and_stop;
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
